/* common/ctps_defs.vh */
// Purpose: constants for the camera trigger pulse system
// Assumes: 50 MHz system clock, byte-free word register port
// Notes:   offsets are word indices on the plain register port
`ifndef CTPS_DEFS_VH
`define CTPS_DEFS_VH

`define CTPS_CLK_HZ        50000000
`define CTPS_CYC_PER_US    (`CTPS_CLK_HZ / 1000000)

// Register indices
`define CTPS_R_CTRL        5'h00
`define CTPS_R_SRCSEL      5'h01
`define CTPS_R_SWTRIG      5'h02
`define CTPS_R_GENPER      5'h03
`define CTPS_R_SPACING     5'h04
`define CTPS_R_SEQCNT      5'h05
`define CTPS_R_DEBOUNCE    5'h06
`define CTPS_R_ROUTE       5'h07
`define CTPS_R_STATUS      5'h08
`define CTPS_R_QLEVEL      5'h09
`define CTPS_R_FLOSS       5'h0a
`define CTPS_R_WIDTH0      5'h10
`define CTPS_R_DELAY0      5'h14
`define CTPS_R_DOWN0       5'h18
`define CTPS_R_INCNT0      5'h1c

// Control bit positions
`define CTPS_C_RUN         0
`define CTPS_C_SSTOP       1
`define CTPS_C_QEN         2
`define CTPS_C_SEQEN       3
`define CTPS_C_BYPASS      4
`define CTPS_C_POL         5

// Source select codes
`define CTPS_SRC_EXT       2'h0
`define CTPS_SRC_GEN       2'h1
`define CTPS_SRC_SW        2'h2

// Status bit positions
`define CTPS_S_QOVF        0
`define CTPS_S_WERR        1
`define CTPS_S_FLOSS       2

// Reset values and limits
`define CTPS_RST_GENPER    32'h0007a120
`define CTPS_RST_SPACING   32'h00000032
`define CTPS_RST_DEBOUNCE  16'h0032
`define CTPS_RST_WIDTH     16'h00c8
`define CTPS_QDEPTH        2000
`define CTPS_SEQ_MAX       65000
`define CTPS_FRAME_TMO     32'h02faf080

`endif

/* hdl/ctps_trigger.v */
// Purpose: trigger generation, queueing, rate valve and four pulse shapers
// Assumes: inputs synchronous to clk; register port with read data one cycle later
// Notes:   camera frame arrival is a one-cycle pulse on frame_seen
`timescale 1ns/1ps
`include "ctps_defs.vh"

module ctps_trigger #(
  parameter NUM_IN   = 4,
  parameter NUM_OUT  = 10,
  parameter NUM_CAM  = 1,
  parameter QDEPTH   = `CTPS_QDEPTH,
  parameter FRAME_TMO = `CTPS_FRAME_TMO
) (
  input  wire                clk,
  input  wire                resetn,
  input  wire [4:0]          reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [31:0]         reg_rdata,
  input  wire [NUM_IN-1:0]   trig_in,
  input  wire                frame_seen,
  output wire [NUM_OUT-1:0]  dig_out,
  output wire [NUM_CAM-1:0]  cam_trig,
  output wire                frame_lost
);

  localparam QW = 11;
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN  = 3'b010;
  localparam ST_STOP = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  reg  [5:0]  ctrl_q;
  reg  [1:0]  trigger_source_select;
  reg  [31:0] gen_period_q;
  reg  [31:0] spacing_q;
  reg  [15:0] seq_count_q;
  reg  [15:0] debounce_q;
  reg  [31:0] route_q;
  reg  [15:0] shaper_pulse_width [0:3];
  reg  [15:0] delay_us_q [0:3];
  reg  [15:0] down_q [0:3];
  reg  [2:0]  status_q;
  reg  [31:0] floss_cnt_q;
  reg         sw_pulse;
  wire [31:0] in_cnt [0:NUM_IN-1];
  wire [3:0]  shp_out;
  wire [NUM_IN-1:0] deb;
  wire        run = ctrl_q[`CTPS_C_RUN];
  reg  [2:0]  trigger_run_control;
  reg  [QW-1:0] q_level_q;
  reg         werr_set;
  reg         qovf_set;
  reg         floss_set;
  wire        enable_out;

  // Width check: width in microseconds against generator period in clock cycles
  function width_bad;
    input [15:0] w_us;
    input [31:0] per_cyc;
    begin
      width_bad = ({16'h0000, w_us} * `CTPS_CYC_PER_US) > per_cyc;
    end
  endfunction

  // Register writes and sticky status
  integer i;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 6'h00;
      trigger_source_select <= `CTPS_SRC_EXT;
      gen_period_q <= `CTPS_RST_GENPER;
      spacing_q <= `CTPS_RST_SPACING;
      seq_count_q <= 16'h0001;
      debounce_q <= `CTPS_RST_DEBOUNCE;
      route_q <= 32'h00000000;
      sw_pulse <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        shaper_pulse_width[i] <= `CTPS_RST_WIDTH;
        delay_us_q[i] <= 16'h0000;
        down_q[i] <= 16'h0000;
      end
    end else begin
      sw_pulse <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `CTPS_R_CTRL:     ctrl_q <= reg_wdata[5:0];
          `CTPS_R_SRCSEL:   trigger_source_select <= reg_wdata[1:0];
          `CTPS_R_SWTRIG:   sw_pulse <= reg_wdata[0];
          `CTPS_R_GENPER:   gen_period_q <= reg_wdata;
          `CTPS_R_SPACING:  spacing_q <= reg_wdata;
          `CTPS_R_SEQCNT:   seq_count_q <= (reg_wdata[15:0] > 16'hfde8) ?
                                           16'hfde8 : reg_wdata[15:0];
          `CTPS_R_DEBOUNCE: debounce_q <= reg_wdata[15:0];
          `CTPS_R_ROUTE:    route_q <= reg_wdata;
          default: begin
            // width in us, reject too long
            if (reg_addr[4:2] == 3'b100 &&
                !width_bad(reg_wdata[15:0], gen_period_q))
              shaper_pulse_width[reg_addr[1:0]] <= reg_wdata[15:0];
            if (reg_addr[4:2] == 3'b101)
              delay_us_q[reg_addr[1:0]] <= reg_wdata[15:0];
            if (reg_addr[4:2] == 3'b110)
              down_q[reg_addr[1:0]] <= reg_wdata[15:0];
          end
        endcase
      end
    end
  end

  always @* begin
    werr_set = reg_wr && reg_addr[4:2] == 3'b100 && width_bad(reg_wdata[15:0], gen_period_q);
  end

  // Sticky status, set wins over clear-on-write
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      status_q <= 3'b000;
    else begin
      if (reg_wr && reg_addr == `CTPS_R_STATUS)
        status_q <= status_q & ~reg_wdata[2:0];
      if (qovf_set)
        status_q[`CTPS_S_QOVF] <= 1'b1;
      if (werr_set)
        status_q[`CTPS_S_WERR] <= 1'b1;
      if (floss_set)
        status_q[`CTPS_S_FLOSS] <= 1'b1;
    end
  end

  // Read mux, data one cycle after strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else if (reg_rd) begin
      case (reg_addr)
        `CTPS_R_CTRL:     reg_rdata <= {26'h0, ctrl_q};
        `CTPS_R_SRCSEL:   reg_rdata <= {30'h0, trigger_source_select};
        `CTPS_R_GENPER:   reg_rdata <= gen_period_q;
        `CTPS_R_SPACING:  reg_rdata <= spacing_q;
        `CTPS_R_SEQCNT:   reg_rdata <= {16'h0, seq_count_q};
        `CTPS_R_DEBOUNCE: reg_rdata <= {16'h0, debounce_q};
        `CTPS_R_ROUTE:    reg_rdata <= route_q;
        `CTPS_R_STATUS:   reg_rdata <= {21'h0, trigger_run_control, shp_out, 1'b0, status_q};
        `CTPS_R_QLEVEL:   reg_rdata <= {21'h0, q_level_q};
        `CTPS_R_FLOSS:    reg_rdata <= floss_cnt_q;
        default: begin
          case (reg_addr[4:2])
            3'b100:  reg_rdata <= {16'h0, shaper_pulse_width[reg_addr[1:0]]};
            3'b101:  reg_rdata <= {16'h0, delay_us_q[reg_addr[1:0]]};
            3'b110:  reg_rdata <= {16'h0, down_q[reg_addr[1:0]]};
            3'b111:  reg_rdata <= in_cnt[reg_addr[1:0]];
            default: reg_rdata <= 32'h00000000;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input stage: debounce, edge, count
  wire [NUM_IN-1:0] fall_ev;
  genvar g;
  generate
    for (g = 0; g < NUM_IN; g = g + 1) begin : g_in
      reg [15:0] db_cnt_q;
      reg        db_q;
      reg        db_d1_q;
      reg [31:0] pcnt_q;
      wire       lvl = trig_in[g] ^ ctrl_q[`CTPS_C_POL];
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          db_cnt_q <= 16'h0000;
          db_q <= 1'b0;
          db_d1_q <= 1'b0;
          pcnt_q <= 32'h00000000;
        end else begin
          db_d1_q <= db_q;
          if (lvl == db_q)
            db_cnt_q <= 16'h0000;
          else if (db_cnt_q >= debounce_q) begin
            db_q <= lvl;
            db_cnt_q <= 16'h0000;
          end else
            db_cnt_q <= db_cnt_q + 16'h0001;
          if (db_q && !db_d1_q)
            pcnt_q <= pcnt_q + 32'h00000001;
        end
      end
      assign deb[g] = db_q;
      assign in_cnt[g] = pcnt_q;
      assign fall_ev[g] = db_q && !db_d1_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Frequency generator
  reg [31:0] gen_cnt_q;
  wire gen_pulse = run && (gen_cnt_q == 32'h0);
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      gen_cnt_q <= 32'h0;
    else if (!run || gen_cnt_q >= gen_period_q - 32'h1)
      gen_cnt_q <= 32'h0;
    else
      gen_cnt_q <= gen_cnt_q + 32'h1;
  end

  reg src_pulse;
  always @* begin
    case (trigger_source_select)
      `CTPS_SRC_EXT: src_pulse = fall_ev[route_q[25:24]];
      `CTPS_SRC_GEN: src_pulse = gen_pulse;
      `CTPS_SRC_SW:  src_pulse = sw_pulse;
      default:       src_pulse = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, queue and valve
  reg  [31:0] space_q;
  reg  [15:0] seq_left_q;
  wire valve_open = (space_q == 32'h0);
  wire seq_busy = (seq_left_q != 16'h0);
  wire pend = (q_level_q != {QW{1'b0}}) || seq_busy;
  wire accept = run && enable_out && valve_open && (pend || src_pulse);
  wire in_now = run && src_pulse && !(valve_open && !pend);
  wire qpush = in_now && ctrl_q[`CTPS_C_QEN] && (q_level_q < QDEPTH[QW-1:0]);
  always @* begin
    qovf_set = in_now && ctrl_q[`CTPS_C_QEN] && (q_level_q >= QDEPTH[QW-1:0]);
  end
  wire qpop = accept && !seq_busy && (q_level_q != {QW{1'b0}});
  wire seq_mul = ctrl_q[`CTPS_C_SEQEN] && (seq_count_q > 16'h1);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      space_q <= 32'h0;
      q_level_q <= {QW{1'b0}};
      seq_left_q <= 16'h0;
    end else begin
      if (accept)
        space_q <= spacing_q;
      else if (space_q != 32'h0)
        space_q <= space_q - 32'h1;
      // queue count, drop when queue off
      q_level_q <= q_level_q + {{(QW-1){1'b0}}, qpush} - {{(QW-1){1'b0}}, qpop};
      if (accept && seq_busy)
        seq_left_q <= seq_left_q - 16'h1;
      else if (accept && seq_mul)
        seq_left_q <= seq_count_q - 16'h1;
      if (!run)
        seq_left_q <= 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run control with synchronous stop
  wire any_active;
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      trigger_run_control <= ST_IDLE;
    else begin
      case (trigger_run_control)
        ST_IDLE: if (run && !ctrl_q[`CTPS_C_SSTOP]) trigger_run_control <= ST_RUN;
        ST_RUN:  if (!run || ctrl_q[`CTPS_C_SSTOP]) trigger_run_control <= ST_STOP;
        ST_STOP: if (!any_active) trigger_run_control <= ST_IDLE;
        default: trigger_run_control <= ST_IDLE;
      endcase
    end
  end
  assign enable_out = (trigger_run_control == ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Four pulse shapers
  wire [3:0] busy;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_shp
      reg [15:0] dcnt_q;
      reg [31:0] dly_q;
      reg [31:0] wid_q;
      reg        out_q;
      reg        armed_q;
      wire [31:0] wcyc = {16'h0, shaper_pulse_width[g]} * `CTPS_CYC_PER_US;
      wire [31:0] dcyc = {16'h0, delay_us_q[g]} * `CTPS_CYC_PER_US;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          dcnt_q <= 16'h0;
          dly_q <= 32'h0;
          wid_q <= 32'h0;
          out_q <= 1'b0;
          armed_q <= 1'b0;
        end else begin
          if (accept && !armed_q && !out_q) begin
            if (dcnt_q >= down_q[g]) begin
              dcnt_q <= 16'h0;
              armed_q <= 1'b1;
              dly_q <= dcyc;
            end else
              dcnt_q <= dcnt_q + 16'h1;
          end else if (armed_q) begin
            if (dly_q == 32'h0) begin
              armed_q <= 1'b0;
              out_q <= 1'b1;
              wid_q <= (wcyc == 32'h0) ? 32'h1 : wcyc;
            end else
              dly_q <= dly_q - 32'h1;
          end else if (out_q) begin
            if (wid_q <= 32'h1)
              out_q <= 1'b0;
            wid_q <= wid_q - 32'h1;
          end
        end
      end
      assign shp_out[g] = out_q;
      assign busy[g] = out_q || armed_q;
    end
  endgenerate
  assign any_active = |busy;

  ////////////////////////////////////////////////////////////////////////////
  // Output routing
  // bypass keeps input shape
  wire [3:0] src_sig = ctrl_q[`CTPS_C_BYPASS] ? {4{deb[route_q[25:24]]}} : shp_out;
  integer k;
  reg [NUM_OUT-1:0] dig_q;
  reg [NUM_CAM-1:0] cam_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dig_q <= {NUM_OUT{1'b0}};
      cam_q <= {NUM_CAM{1'b0}};
    end else begin
      for (k = 0; k < NUM_OUT; k = k + 1)
        dig_q[k] <= src_sig[route_q[(2*k)%20 +: 2]];
      for (k = 0; k < NUM_CAM; k = k + 1)
        cam_q[k] <= src_sig[route_q[21:20]];
    end
  end
  assign dig_out = dig_q;
  assign cam_trig = cam_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame loss watchdog
  reg [31:0] wd_q;
  reg        cam_d1_q;
  reg        lost_q;
  always @* floss_set = (wd_q == 32'h1) && !frame_seen;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_q <= 32'h0;
      cam_d1_q <= 1'b0;
      lost_q <= 1'b0;
      floss_cnt_q <= 32'h0;
    end else begin
      cam_d1_q <= cam_q[0];
      lost_q <= floss_set;
      if (frame_seen)
        wd_q <= 32'h0;
      else if (cam_q[0] && !cam_d1_q && wd_q == 32'h0)
        wd_q <= FRAME_TMO;
      else if (wd_q != 32'h0)
        wd_q <= wd_q - 32'h1;
      if (floss_set)
        floss_cnt_q <= floss_cnt_q + 32'h1;
    end
  end
  assign frame_lost = lost_q;

endmodule

/* sim/ctps_trigger_props.sv */
// Purpose: port assertions for the trigger pulse system
// Assumes: camera fed by shaper 0, route and widths fixed while running
// Notes:   helper logic shadows the register writes it needs
`timescale 1ns/1ps
`include "ctps_defs.vh"
module ctps_props #(
  parameter NUM_IN    = 4,
  parameter NUM_OUT   = 10,
  parameter NUM_CAM   = 1,
  parameter QDEPTH    = 2000,
  parameter FRAME_TMO = 100
) (
  input wire               clk,
  input wire               resetn,
  input wire [4:0]         reg_addr,
  input wire [31:0]        reg_wdata,
  input wire               reg_wr,
  input wire               reg_rd,
  input wire [31:0]        reg_rdata,
  input wire [NUM_IN-1:0]  trig_in,
  input wire               frame_seen,
  input wire [NUM_OUT-1:0] dig_out,
  input wire [NUM_CAM-1:0] cam_trig,
  input wire               frame_lost
);
  logic [31:0] w0_q, d0_q, sp_q, per_q, hi_q, gap_q, lost_q, stp_q;
  logic        byp_q, stop_q, ran_q, seen_q, cam_q;
  wire         rise = cam_trig[0] && !cam_q;
  wire         wr_c = reg_wr && reg_addr == `CTPS_R_CTRL;
  ////////////////////////////////////////////////////////////
  // Shadow settings, count high time, gaps and quiet spans
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w0_q  <= {16'h0, `CTPS_RST_WIDTH};
      d0_q  <= 32'h0;
      sp_q  <= `CTPS_RST_SPACING;
      per_q <= `CTPS_RST_GENPER;
      {hi_q, gap_q, lost_q, stp_q} <= '0;
      {byp_q, stop_q, ran_q, seen_q, cam_q} <= '0;
    end else begin
      cam_q  <= cam_trig[0];
      hi_q   <= cam_trig[0] ? hi_q + 32'h1 : 32'h0;
      gap_q  <= rise ? 32'h1 : gap_q + 32'h1;
      lost_q <= frame_seen ? 32'h0 : lost_q + 32'h1;
      stp_q  <= stop_q ? stp_q + 32'h1 : 32'h0;
      if (rise) seen_q <= 1'b1;
      if (reg_wr && reg_addr == `CTPS_R_SPACING) sp_q <= reg_wdata;
      if (reg_wr && reg_addr == `CTPS_R_GENPER) per_q <= reg_wdata;
      if (reg_wr && reg_addr == `CTPS_R_DELAY0) d0_q <= {16'h0, reg_wdata[15:0]};
      if (reg_wr && reg_addr == `CTPS_R_WIDTH0 && reg_wdata[15:0] * 50 <= per_q) begin
        w0_q <= {16'h0, reg_wdata[15:0]};
      end
      if (wr_c) begin
        ran_q  <= 1'b1;
        byp_q  <= reg_wdata[`CTPS_C_BYPASS];
        stop_q <= reg_wdata[`CTPS_C_SSTOP] || !reg_wdata[`CTPS_C_RUN];
      end
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_unmap_rd;
    reg_rd && reg_addr >= 5'h0b && reg_addr <= 5'h0f;
  endsequence
  sequence s_shaped_fall;
    $fell(cam_trig[0]) && !byp_q;
  endsequence
  a_unmap_zero: assert property (s_unmap_rd |=> reg_rdata == 32'h0)
    else $error("unmapped read gave data");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_width_exact: assert property (s_shaped_fall |-> hi_q == w0_q * 50)
    else $error("camera pulse length wrong");
  a_valve_gap: assert property (rise && seen_q && !byp_q |-> gap_q + 1 >= sp_q)
    else $error("camera pulses closer than spacing");
  a_stop_halt: assert property (stop_q && !byp_q && stp_q > d0_q * 50 + 6 |-> !rise)
    else $error("pulse after synchronous stop");
  a_idle_quiet: assert property (!ran_q |-> !cam_trig[0] && dig_out == '0 && !frame_lost)
    else $error("output before activation");
  a_lost_single: assert property (frame_lost |=> !frame_lost)
    else $error("frame loss pulse too long");
  a_lost_late: assert property (frame_lost |-> lost_q >= FRAME_TMO)
    else $error("frame loss before timeout");
endmodule
bind ctps_trigger ctps_props #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT), .NUM_CAM(NUM_CAM),
  .QDEPTH(QDEPTH), .FRAME_TMO(FRAME_TMO)) ctps_props_inst (.clk(clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .trig_in(trig_in), .frame_seen(frame_seen),
  .dig_out(dig_out), .cam_trig(cam_trig), .frame_lost(frame_lost));

/* sim/ctps_cam_model.sv */
// Purpose: camera on the link, answers each trigger with a frame
// Assumes: one frame per trigger rise, fixed latency
// Notes:   drop sampled at the rise withholds that frame
`timescale 1ns/1ps
module ctps_cam_model #(
  parameter LAT = 20
) (
  input  wire  clk,
  input  wire  resetn,
  input  wire  cam_trig,
  input  wire  drop,
  output logic frame_seen
);
  logic       trig_q, drop_q;
  logic [7:0] cnt_q;
  // Latency count after each trigger rise, then one frame pulse
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_q     <= 1'b0;
      drop_q     <= 1'b0;
      cnt_q      <= 8'h00;
      frame_seen <= 1'b0;
    end else begin
      trig_q     <= cam_trig;
      frame_seen <= 1'b0;
      if (cam_trig && !trig_q) begin
        cnt_q  <= LAT;
        drop_q <= drop;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) frame_seen <= !drop_q;
      end
    end
  end
endmodule

/* sim/ctps_trigger_bench.sv */
// Purpose: self-checking bench for the trigger pulse system
// Assumes: frame timeout shortened to 100 cycles
// Notes:   camera shaper 0, width 4 us, spacing 300 cycles
`timescale 1ns/1ps
`include "ctps_defs.vh"
module ctps_trigger_bench;
  logic        clk = 0, resetn, reg_wr, reg_rd, frame_seen, frame_lost, cam_trig, drop;
  logic        cam_d = 0, dig_d = 0;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v, seed, cam_n = 0, dig_n = 0, lost_n = 0;
  logic [31:0] hi_c = 0, hi_w = 0;
  logic [3:0]  trig_in;
  logic [9:0]  dig_out;
  int          err_count = 0, num_checks = 0, n, i;
  ctps_trigger #(.FRAME_TMO(100)) ctps_trigger_inst (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_in(trig_in), .frame_seen(frame_seen),
    .dig_out(dig_out), .cam_trig(cam_trig), .frame_lost(frame_lost));
  ctps_cam_model ctps_cam_model_inst (.clk(clk), .resetn(resetn), .cam_trig(cam_trig),
    .drop(drop), .frame_seen(frame_seen));
  ////////////////////////////////////////////////////////////
  // Clock and output monitors
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cam_trig && !cam_d) cam_n <= cam_n + 1;
    if (dig_out[0] && !dig_d) dig_n <= dig_n + 1;
    if (frame_lost) lost_n <= lost_n + 1;
    hi_c  <= cam_trig ? hi_c + 1 : 0;
    if (!cam_trig && cam_d) hi_w <= hi_c;
    cam_d <= cam_trig;
    dig_d <= dig_out[0];
  end
  ////////////////////////////////////////////////////////////
  function automatic [31:0] wcyc(input [31:0] us);
    return us * `CTPS_CYC_PER_US;
  endfunction
  function automatic [31:0] w_keep(input [31:0] nw, od, per);
    return (wcyc(nw) <= per) ? nw : od;
  endfunction
  function automatic [31:0] pulses_out(input [31:0] k, down);
    return k / (down + 1);
  endfunction
  task chk(input [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task wr(input [4:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task rd(input [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task clr;
    @(negedge clk);
    cam_n  = 0;
    dig_n  = 0;
    lost_n = 0;
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    seed = 32'h8ed9dcef;
    {resetn, reg_wr, reg_rd, drop} = 4'h0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    trig_in = 4'h0;
    tick(5);
    resetn <= 1'b1;
    rd(5'h04); chk(v, `CTPS_RST_SPACING);
    rd(5'h03); chk(v, `CTPS_RST_GENPER);
    rd(5'h10); chk(v, {16'h0, `CTPS_RST_WIDTH});
    rd(5'h08); chk(v, 32'h100);
    rd(5'h0b); chk(v, 32'h0);
    done("reset");
    wr(5'h03, 1000);
    wr(5'h10, 21);
    rd(5'h10); chk(v, w_keep(21, 200, 1000));
    rd(5'h08); chk(v[1], 1);
    for (i = 0; i < 4; i++) wr(5'h10 + 5'(i), 4);
    rd(5'h10); chk(v, w_keep(4, 200, 1000));
    done("width");
    wr(5'h04, 300);
    wr(5'h07, $random(seed) & 32'h000ffffc);
    wr(5'h01, `CTPS_SRC_SW);
    wr(5'h00, 1);
    clr; wr(5'h02, 1); wr(5'h02, 1); tick(600);
    chk(cam_n, 1);
    chk(dig_n, 1);
    chk(hi_w, wcyc(4));
    done("drop");
    wr(5'h00, 5);
    clr; repeat (3) wr(5'h02, 1); tick(1200);
    chk(cam_n, 3);
    rd(5'h09); chk(v, 0);
    done("queue");
    wr(5'h05, 32'hffff);
    rd(5'h05); chk(v, `CTPS_SEQ_MAX);
    wr(5'h05, 4); wr(5'h18, 1); wr(5'h00, 9);
    clr; wr(5'h02, 1); tick(1800);
    chk(cam_n, pulses_out(4, 1));
    wr(5'h18, 0); wr(5'h05, 1); wr(5'h00, 1);
    done("sequence");
    drop <= 1'b1;
    clr; wr(5'h02, 1); tick(400);
    drop <= 1'b0;
    chk(lost_n, 1);
    rd(5'h08); chk(v[2], 1);
    rd(5'h0a); chk(v, 1);
    wr(5'h08, 4);
    rd(5'h08); chk(v[2], 0);
    done("loss");
    wr(5'h00, 0); tick(300); wr(5'h01, `CTPS_SRC_GEN); wr(5'h00, 1);
    clr; tick(3100); wr(5'h00, 0);
    chk(cam_n inside {[3:4]}, 1);
    done("generator");
    tick(300); wr(5'h01, `CTPS_SRC_SW); wr(5'h00, 1);
    clr; wr(5'h02, 1); tick(50);
    rd(5'h08); chk(v[4], 1);
    wr(5'h00, 3);
    rd(5'h08); chk(v[10:8], 4);
    tick(300); wr(5'h02, 1); tick(400);
    chk(cam_n, 1);
    chk(hi_w, wcyc(4));
    rd(5'h08); chk(v[10:8], 1);
    done("stop");
    wr(5'h01, `CTPS_SRC_EXT); wr(5'h00, 1);
    clr; n = 4 + ($random(seed) & 3);
    for (i = 0; i < n; i++) begin
      trig_in <= {3'($random(seed)), 1'b1};
      tick(200 + ($random(seed) & 31));
      trig_in[0] <= 1'b0;
      tick(200 + ($random(seed) & 31));
    end
    tick(500);
    chk(cam_n, n);
    rd(5'h1c); chk(v, n);
    done("external");
    wr(5'h00, 32'h11); tick(100);
    trig_in[0] <= 1'b1; tick(77);
    trig_in[0] <= 1'b0; tick(150);
    chk(hi_w, 77);
    done("bypass");
    wr(5'h00, 32'h31); tick(100);
    chk(cam_trig, 1);
    rd(5'h1c); chk(v, n + 2);
    done("invert");
    tally_and_finish;
  end
endmodule
